// ===== lcl_led_control.sv
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module lcl_led_control
  import lcl_pkg::*;
(
  input  wire logic        i_core_clk,      // device clock, 250 MHz
  input  wire logic        i_reset,         // synchronous reset, active high
  input  wire logic [3:0]  i_s_axi_awaddr,  // write address
  input  wire logic        i_s_axi_awvalid, // write address valid
  output logic             o_s_axi_awready, // write address ready
  input  wire logic [31:0] i_s_axi_wdata,   // write data
  input  wire logic [3:0]  i_s_axi_wstrb,   // write byte enables
  input  wire logic        i_s_axi_wvalid,  // write data valid
  output logic             o_s_axi_wready,  // write data ready
  output logic [1:0]       o_s_axi_bresp,   // write response
  output logic             o_s_axi_bvalid,  // write response valid
  input  wire logic        i_s_axi_bready,  // write response ready
  input  wire logic [3:0]  i_s_axi_araddr,  // read address
  input  wire logic        i_s_axi_arvalid, // read address valid
  output logic             o_s_axi_arready, // read address ready
  output logic [31:0]      o_s_axi_rdata,   // read data
  output logic [1:0]       o_s_axi_rresp,   // read response
  output logic             o_s_axi_rvalid,  // read data valid
  input  wire logic        i_s_axi_rready,  // read data ready
  input  wire logic        i_hdr_valid,     // frame header received, pulse
  input  wire logic [7:0]  i_hdr_id,        // protected identifier
  input  wire logic        i_rx_valid,      // received byte, pulse
  input  wire logic [7:0]  i_rx_data,       // received byte value
  output logic             o_tx_valid,      // response byte offered
  output logic [7:0]       o_tx_data,       // response byte value
  output logic             o_tx_last,       // offered byte is the checksum
  input  wire logic        i_tx_ready,      // response byte taken
  input  wire logic [10:0] i_mod_value1,    // calibrated modulation, LED 1
  input  wire logic [10:0] i_mod_value2,    // calibrated modulation, LED 2
  input  wire logic [10:0] i_mod_value3,    // calibrated modulation, LED 3
  input  wire logic [2:0]  i_mod_overflow,  // overflow flags, LED 3..1
  input  wire logic [3:0]  i_intensity,     // current intensity
  input  wire logic        i_fade_enable,   // fade on
  input  wire logic        i_fade_curve,    // fade curve select
  input  wire logic [5:0]  i_fade_duration, // fade duration
  output logic             o_calibration_enable,          // calibration on
  output logic             o_modulation_frequency_select, // modulation rate
  output logic             o_led_master_switch,           // all LEDs on
  output logic             o_thermal_control,             // thermal control on
  output logic [2:0]       o_channel_enable,              // channel 3..1 enables
  output logic             o_irq                          // interrupt, level
);

  lcl_state_e  state;
  logic [6:0]  ctrl_bits;
  logic [5:0]  node_address;
  logic [3:0]  group_membership;
  logic        command_disable_bit;
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] mask;
  logic [ST_W-1:0] st_set;
  logic [ST_W-1:0] st_clr;
  logic [7:0]  rx_buf [0:4];
  logic [2:0]  rx_count;
  logic [2:0]  rx_len;
  logic        rx_is_wr;
  logic        pending;
  logic        tx_color;
  logic [3:0]  tx_idx;
  logic [3:0]  tx_len;
  logic [3:0]  resp_idx;
  logic [7:0]  resp_byte;
  logic [7:0]  rx_cks;
  logic [7:0]  tx_cks;
  logic [15:0] group_mask;
  logic        wr_hit;
  logic        tx_take;
  logic        rx_data_byte;
  logic        rx_sum_byte;
  logic        hdr_ok;
  logic [3:0]  aw_addr;
  logic        aw_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_held;
  logic        do_write;
  logic [31:0] cfg_word;
  logic [31:0] next_cfg;
  assign tx_take      = o_tx_valid && i_tx_ready;
  assign hdr_ok       = i_hdr_valid && !command_disable_bit;
  assign rx_data_byte = (state == S_RX) && i_rx_valid && (rx_count < rx_len);
  assign rx_sum_byte  = (state == S_RX) && i_rx_valid && (rx_count == rx_len);
  assign group_mask   = {rx_buf[2], rx_buf[1]};
  assign wr_hit       = rx_buf[0][7] ? (rx_buf[0][5:0] == node_address) :
                        group_mask[group_membership];

  lcl_cksum u_rx_cks (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_clear    (i_hdr_valid),
    .i_add      (rx_data_byte),
    .i_byte     (i_rx_data),
    .o_sum      (rx_cks)
  );
  lcl_cksum u_tx_cks (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_clear    (i_hdr_valid),
    .i_add      (tx_take && (state == S_TX)),
    .i_byte     (o_tx_data),
    .o_sum      (tx_cks)
  );
  // byte to load: the current one, or the next once it is offered
  assign resp_idx = tx_idx + {3'h0, o_tx_valid};
  always_comb begin
    resp_byte = {ADDR_TOP, node_address};
    if (tx_color) begin
      case (resp_idx)
        4'h1: resp_byte = i_mod_value1[7:0];
        4'h2: resp_byte = {FILL_NIB, i_mod_overflow[0], i_mod_value1[10:8]};
        4'h3: resp_byte = i_mod_value2[7:0];
        4'h4: resp_byte = {FILL_NIB, i_mod_overflow[1], i_mod_value2[10:8]};
        4'h5: resp_byte = i_mod_value3[7:0];
        4'h6: resp_byte = {i_intensity, i_mod_overflow[2], i_mod_value3[10:8]};
        4'h7: resp_byte = {i_fade_enable, i_fade_curve, i_fade_duration};
      endcase
    end else if (resp_idx == 4'h1) begin
      resp_byte = {ctrl_bits, 1'b1};
    end
  end
  // frame sequencer; a new header always restarts it
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state      <= S_IDLE;
      rx_count   <= 3'h0;
      rx_len     <= 3'h0;
      rx_is_wr   <= 1'b0;
      tx_color   <= 1'b0;
      tx_idx     <= 4'h0;
      tx_len     <= 4'h0;
      o_tx_valid <= 1'b0;
      o_tx_data  <= 8'h00;
      o_tx_last  <= 1'b0;
    end else if (i_hdr_valid) begin
      state      <= S_IDLE;
      rx_count   <= 3'h0;
      tx_idx     <= 4'h0;
      o_tx_valid <= 1'b0;
      o_tx_last  <= 1'b0;
      if (hdr_ok && (i_hdr_id == REQ_ID)) begin
        state    <= S_RX;
        rx_len   <= REQ_LEN;
        rx_is_wr <= 1'b0;
      end else if (hdr_ok && (i_hdr_id == CTRL_WR_ID)) begin
        state    <= S_RX;
        rx_len   <= WR_LEN;
        rx_is_wr <= 1'b1;
      end else if (hdr_ok && pending && (i_hdr_id == COLOR_RESP_ID)) begin
        state    <= S_TX;
        tx_color <= 1'b1;
        tx_len   <= COLOR_LEN;
      end else if (hdr_ok && pending && (i_hdr_id == CTRL_RESP_ID)) begin
        state    <= S_TX;
        tx_color <= 1'b0;
        tx_len   <= CTRL_LEN;
      end
    end else begin
      case (state)
        S_RX: begin
          if (rx_data_byte) begin
            rx_count <= rx_count + 3'h1;
          end else if (rx_sum_byte) begin
            state <= S_IDLE;
          end
        end
        S_TX: begin
          if (!o_tx_valid) begin
            o_tx_valid <= 1'b1;
            o_tx_data  <= resp_byte;
          end else if (tx_take) begin
            if (tx_idx == tx_len - 4'h1) begin
              o_tx_valid <= 1'b0;
              state      <= S_TXSUM;
            end else begin
              tx_idx    <= tx_idx + 4'h1;
              o_tx_data <= resp_byte;
            end
          end
        end
        S_TXSUM: begin
          if (!o_tx_valid) begin
            o_tx_valid <= 1'b1;
            o_tx_data  <= tx_cks;
            o_tx_last  <= 1'b1;
          end else if (tx_take) begin
            o_tx_valid <= 1'b0;
            o_tx_last  <= 1'b0;
            state      <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (rx_data_byte) begin
      rx_buf[rx_count] <= i_rx_data;
    end
  end
  // read request arms one answer; a served answer disarms, a new request rearms only if its checksum and address match
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      pending <= 1'b0;
    end else if (rx_sum_byte && !rx_is_wr) begin
      pending <= (i_rx_data == rx_cks) && (rx_buf[0] == {ADDR_TOP, node_address})
                 && (rx_buf[1] == FILL_BYTE);
    end else if ((state == S_TXSUM) && tx_take) begin
      pending <= 1'b0;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      ctrl_bits <= CONTROL_RESET;
    end else if (rx_sum_byte && rx_is_wr && (i_rx_data == rx_cks) && wr_hit) begin
      ctrl_bits <= rx_buf[3][7:1];
    end
  end
  assign o_calibration_enable          = ctrl_bits[CB_CAL_EN - 1];
  assign o_modulation_frequency_select = ctrl_bits[CB_FREQ - 1];
  assign o_led_master_switch           = ctrl_bits[CB_MASTER - 1];
  assign o_thermal_control             = ctrl_bits[CB_THERMAL - 1];
  assign o_channel_enable              = ctrl_bits[CB_CH3 - 1:CB_CH1 - 1];
  always_comb begin
    st_set = '0;
    st_set[ST_CTRL_WRITE] = rx_sum_byte && rx_is_wr && (i_rx_data == rx_cks) && wr_hit;
    st_set[ST_CKSUM_ERR]  = rx_sum_byte && (i_rx_data != rx_cks);
    st_set[ST_READBACK]   = (state == S_TXSUM) && tx_take;
  end
  // register bus: address and data held independently, write when both are in
  assign do_write = aw_held && w_held && !o_s_axi_bvalid;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      aw_held         <= 1'b0;
      aw_addr         <= 4'h0;
      w_held          <= 1'b0;
      w_data          <= 32'h0000_0000;
      w_strb          <= 4'h0;
      o_s_axi_awready <= 1'b1;
      o_s_axi_wready  <= 1'b1;
      o_s_axi_bvalid  <= 1'b0;
      o_s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (o_s_axi_awready && i_s_axi_awvalid) begin
        aw_held         <= 1'b1;
        aw_addr         <= i_s_axi_awaddr;
        o_s_axi_awready <= 1'b0;
      end
      if (o_s_axi_wready && i_s_axi_wvalid) begin
        w_held         <= 1'b1;
        w_data         <= i_s_axi_wdata;
        w_strb         <= i_s_axi_wstrb;
        o_s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held        <= 1'b0;
        w_held         <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        if (((aw_addr & 4'hC) == ADDR_CONFIG) || ((aw_addr & 4'hC) == ADDR_CONTROL) ||
            ((aw_addr & 4'hC) == ADDR_STATUS) || ((aw_addr & 4'hC) == ADDR_MASK)) begin
          o_s_axi_bresp <= RESP_OKAY;
        end else begin
          o_s_axi_bresp <= RESP_SLVERR;
        end
      end else if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid  <= 1'b0;
        o_s_axi_awready <= 1'b1;
        o_s_axi_wready  <= 1'b1;
      end
    end
  end

  assign cfg_word = {15'h0000, command_disable_bit, 4'h0, group_membership,
                     2'h0, node_address};

  always_comb begin
    next_cfg = cfg_word;
    for (int b = 0; b < 4; b++) begin
      if (w_strb[b]) begin
        next_cfg[b*8 +: 8] = w_data[b*8 +: 8];
      end
    end
  end

  // command disable can only be set; it clears at reset
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      node_address        <= NODE_RESET;
      group_membership    <= GROUP_RESET;
      command_disable_bit <= 1'b0;
    end else if (do_write && ((aw_addr & 4'hC) == ADDR_CONFIG)) begin
      node_address        <= next_cfg[CFG_NODE_LSB +: 6];
      group_membership    <= next_cfg[CFG_GROUP_LSB +: 4];
      command_disable_bit <= command_disable_bit | next_cfg[CFG_CMDOFF];
    end
  end

  assign st_clr = (do_write && ((aw_addr & 4'hC) == ADDR_STATUS) && w_strb[0]) ?
                  w_data[ST_W-1:0] : '0;

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      status <= '0;
      mask   <= '0;
      o_irq  <= 1'b0;
    end else begin
      status <= (status & ~st_clr) | st_set;
      if (do_write && ((aw_addr & 4'hC) == ADDR_MASK) && w_strb[0]) begin
        mask <= w_data[ST_W-1:0];
      end
      o_irq <= |(((status & ~st_clr) | st_set) & mask);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_s_axi_arready <= 1'b1;
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_rdata   <= 32'h0000_0000;
      o_s_axi_rresp   <= RESP_OKAY;
    end else if (o_s_axi_arready && i_s_axi_arvalid) begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid  <= 1'b1;
      o_s_axi_rresp   <= RESP_OKAY;
      if ((i_s_axi_araddr & 4'hC) == ADDR_CONFIG) begin
        o_s_axi_rdata <= cfg_word;
      end else if ((i_s_axi_araddr & 4'hC) == ADDR_CONTROL) begin
        o_s_axi_rdata <= {24'h000000, ctrl_bits, 1'b1};
      end else if ((i_s_axi_araddr & 4'hC) == ADDR_STATUS) begin
        o_s_axi_rdata <= {{(32-ST_W){1'b0}}, status};
      end else if ((i_s_axi_araddr & 4'hC) == ADDR_MASK) begin
        o_s_axi_rdata <= {{(32-ST_W){1'b0}}, mask};
      end else begin
        o_s_axi_rdata <= 32'h0000_0000;
        o_s_axi_rresp <= RESP_SLVERR;
      end
    end else if (o_s_axi_rvalid && i_s_axi_rready) begin
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_arready <= 1'b1;
    end
  end

endmodule // lcl_led_control

// ===== lcl_pkg.sv
package lcl_pkg;

  // frame identifiers as seen on the bus, parity bits included
  localparam logic [7:0] REQ_ID        = 8'h20;
  localparam logic [7:0] COLOR_RESP_ID = 8'h92;
  localparam logic [7:0] CTRL_RESP_ID  = 8'h50;
  localparam logic [7:0] CTRL_WR_ID    = 8'hA3;

  // data bytes per frame, checksum excluded
  localparam logic [2:0] REQ_LEN    = 3'h2;
  localparam logic [2:0] WR_LEN     = 3'h4;
  localparam logic [3:0] COLOR_LEN  = 4'h8;
  localparam logic [3:0] CTRL_LEN   = 4'h2;

  localparam logic [1:0] ADDR_TOP   = 2'h3;
  localparam logic [7:0] FILL_BYTE  = 8'hFF;
  localparam logic [3:0] FILL_NIB   = 4'hF;

  // register byte offsets
  localparam logic [3:0] ADDR_CONFIG  = 4'h0;
  localparam logic [3:0] ADDR_CONTROL = 4'h4;
  localparam logic [3:0] ADDR_STATUS  = 4'h8;
  localparam logic [3:0] ADDR_MASK    = 4'hC;

  // config register fields
  localparam int CFG_NODE_LSB  = 0;
  localparam int CFG_GROUP_LSB = 8;
  localparam int CFG_CMDOFF    = 16;

  // status and mask bits
  localparam int ST_CTRL_WRITE = 0;
  localparam int ST_CKSUM_ERR  = 1;
  localparam int ST_READBACK   = 2;
  localparam int ST_W          = 3;

  // control byte bit positions
  localparam int CB_CAL_EN  = 7;
  localparam int CB_FREQ    = 6;
  localparam int CB_MASTER  = 5;
  localparam int CB_THERMAL = 4;
  localparam int CB_CH3     = 3;
  localparam int CB_CH1     = 1;

  localparam logic [6:0]  CONTROL_RESET = 7'h00;
  localparam logic [5:0]  NODE_RESET    = 6'h00;
  localparam logic [3:0]  GROUP_RESET   = 4'h0;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_RX    = 4'b0010,
    S_TX    = 4'b0100,
    S_TXSUM = 4'b1000
  } lcl_state_e;

endpackage

// ===== lcl_cksum.sv
`timescale 1ns/1ps
module lcl_cksum (
  input  wire logic       i_core_clk, // device clock
  input  wire logic       i_reset,    // synchronous reset
  input  wire logic       i_clear,    // restart the sum
  input  wire logic       i_add,      // add i_byte this cycle
  input  wire logic [7:0] i_byte,     // byte to add
  output logic      [7:0] o_sum       // inverted carry-wrapped sum
);
  logic [7:0] acc;
  logic [8:0] wide;

  assign wide  = {1'b0, acc} + {1'b0, i_byte};
  assign o_sum = ~acc;

  // carry wraps back into bit 0, as the classic checksum requires
  always_ff @(posedge i_core_clk) begin
    if (i_reset || i_clear) begin
      acc <= 8'h00;
    end else if (i_add) begin
      acc <= wide[7:0] + {7'h00, wide[8]};
    end
  end
endmodule // lcl_cksum

// ===== lcl_led_control_props.sv
`timescale 1ns/1ps
module lcl_led_control_props
  import lcl_pkg::*;
(
  input wire logic        i_core_clk, // clock
  input wire logic        i_reset, // reset
  input wire logic        i_hdr_valid, // header
  input wire logic [7:0]  i_hdr_id, // frame id
  input wire logic        i_rx_valid, // rx byte
  input wire logic        i_tx_ready, // tx taken
  input wire logic        o_tx_valid, // tx offered
  input wire logic [7:0]  o_tx_data, // tx byte
  input wire logic        o_tx_last, // checksum byte
  input wire logic [10:0] i_mod_value1, // led 1
  input wire logic [10:0] i_mod_value3, // led 3
  input wire logic [2:0]  i_mod_overflow, // overflows
  input wire logic [3:0]  i_intensity, // intensity
  input wire logic        i_fade_enable, // fade on
  input wire logic        i_fade_curve, // curve
  input wire logic [5:0]  i_fade_duration, // duration
  input wire logic        o_calibration_enable, // control
  input wire logic        o_modulation_frequency_select, // control
  input wire logic        o_led_master_switch, // control
  input wire logic        o_thermal_control, // control
  input wire logic [2:0]  o_channel_enable // control
);
  logic       color;
  logic [3:0] idx;
  logic [6:0] ctl;
  assign ctl = {o_calibration_enable, o_modulation_frequency_select, o_led_master_switch,
                o_thermal_control, o_channel_enable};
  // index of the answer byte on offer, counted from the answer header
  always_ff @(posedge i_core_clk) begin
    if (i_reset || i_hdr_valid) idx <= 4'h0;
    else if (o_tx_valid && i_tx_ready) idx <= idx + 4'h1;
  end
  always_ff @(posedge i_core_clk) begin
    if (i_reset) color <= 1'b0;
    else if (i_hdr_valid) color <= (i_hdr_id == COLOR_RESP_ID);
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  property p_tx_hold;
    o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data) && $stable(o_tx_last);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("answer byte dropped");
  property p_sum_gap;
    $rose(o_tx_last) |-> o_tx_valid && !$past(o_tx_valid) && idx == (color ? COLOR_LEN : CTRL_LEN);
  endproperty
  a_sum_gap: assert property (p_sum_gap) else $error("checksum misplaced");
  property p_ctl_change;
    !$stable(ctl) |-> $past(i_rx_valid) || $past(i_rx_valid, 2);
  endproperty
  a_ctl_change: assert property (p_ctl_change) else $error("control changed unasked");
  property p_low1;
    o_tx_valid && color && idx == 4'h1 |-> o_tx_data == i_mod_value1[7:0];
  endproperty
  a_low1: assert property (p_low1) else $error("led 1 low byte wrong");
  property p_high1;
    o_tx_valid && color && idx == 4'h2 |->
      o_tx_data == {FILL_NIB, i_mod_overflow[0], i_mod_value1[10:8]};
  endproperty
  a_high1: assert property (p_high1) else $error("led 1 high byte wrong");
  property p_high3;
    o_tx_valid && color && idx == 4'h6 |->
      o_tx_data == {i_intensity, i_mod_overflow[2], i_mod_value3[10:8]};
  endproperty
  a_high3: assert property (p_high3) else $error("led 3 high byte wrong");
  property p_fade;
    o_tx_valid && color && idx == 4'h7 |-> o_tx_data == {i_fade_enable, i_fade_curve, i_fade_duration};
  endproperty
  a_fade: assert property (p_fade) else $error("fade byte wrong");
  property p_ctl_byte;
    o_tx_valid && !color && idx == 4'h1 |-> o_tx_data == {ctl, 1'b1};
  endproperty
  a_ctl_byte: assert property (p_ctl_byte) else $error("control byte wrong");
endmodule // lcl_led_control_props

bind lcl_led_control lcl_led_control_props lcl_led_control_props_i (
  .i_core_clk, .i_reset, .i_hdr_valid, .i_hdr_id, .i_rx_valid, .i_tx_ready, .o_tx_valid,
  .o_tx_data, .o_tx_last, .i_mod_value1, .i_mod_value3, .i_mod_overflow, .i_intensity,
  .i_fade_enable, .i_fade_curve, .i_fade_duration, .o_calibration_enable,
  .o_modulation_frequency_select, .o_led_master_switch, .o_thermal_control, .o_channel_enable
);

// ===== lcl_lin_master.sv
`timescale 1ns/1ps
module lcl_lin_master (
  input  wire logic       i_core_clk,  // clock
  output logic            o_hdr_valid, // header pulse
  output logic      [7:0] o_hdr_id,    // frame id
  output logic            o_rx_valid,  // byte pulse
  output logic      [7:0] o_rx_data,   // byte value
  input  wire logic       i_tx_valid,  // answer byte offered
  input  wire logic [7:0] i_tx_data,   // answer byte
  input  wire logic       i_tx_last,   // answer checksum flag
  output logic            o_tx_ready   // answer byte taken
);
  int         stall = 0;
  logic [7:0] got [9];
  logic       lst [9];
  initial begin
    o_hdr_valid = 1'b0;
    o_hdr_id = 8'h00;
    o_rx_valid = 1'b0;
    o_rx_data = 8'h00;
    o_tx_ready = 1'b0;
  end
  function automatic logic [7:0] cks(input logic [7:0] d [9], input int n);
    logic [8:0] s;
    s = 9'h000;
    for (int k = 0; k < n; k++) begin
      s = s + {1'b0, d[k]};
      s = {1'b0, s[7:0]} + {8'h00, s[8]};
    end
    return ~s[7:0];
  endfunction
  // idle lines show the inverse of the last value
  task automatic header(input logic [7:0] id);
    @(posedge i_core_clk);
    o_hdr_valid <= 1'b1;
    o_hdr_id <= id;
    @(posedge i_core_clk);
    o_hdr_valid <= 1'b0;
    o_hdr_id <= ~id;
  endtask
  task automatic put(input logic [7:0] b);
    @(posedge i_core_clk);
    o_rx_valid <= 1'b1;
    o_rx_data <= b;
    @(posedge i_core_clk);
    o_rx_valid <= 1'b0;
    o_rx_data <= ~b;
  endtask
  task automatic send(input logic [7:0] id, input logic [7:0] d [9], input int n,
                      input logic bad);
    header(id);
    for (int k = 0; k < n; k++) put(d[k]);
    put(cks(d, n) ^ {7'h00, bad});
  endtask
  task automatic take(output logic [7:0] b, output logic l);
    if (stall > 0) begin
      o_tx_ready <= 1'b0;
      repeat (stall) @(posedge i_core_clk);
    end
    o_tx_ready <= 1'b1;
    do @(posedge i_core_clk); while (i_tx_valid !== 1'b1);
    b = i_tx_data;
    l = i_tx_last;
  endtask
  task automatic answer(input logic [7:0] id, input int n);
    header(id);
    for (int k = 0; k <= n; k++) take(got[k], lst[k]);
    @(posedge i_core_clk);
    o_tx_ready <= 1'b0;
  endtask
endmodule // lcl_lin_master

// ===== lin_color_readback_led_control_test.sv
`timescale 1ns/1ps
module lin_color_readback_led_control_test;
  import lcl_pkg::*;
  localparam logic [5:0] NODE = 6'h15;
  logic        i_core_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic [3:0]  i_s_axi_awaddr = 4'h0, i_s_axi_araddr = 4'h0, i_s_axi_wstrb = 4'hF;
  logic [31:0] i_s_axi_wdata = 32'h0, rd, o_s_axi_rdata;
  logic        i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
  logic        i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0, o_s_axi_awready;
  logic        o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  logic [1:0]  o_s_axi_bresp, o_s_axi_rresp;
  logic        i_hdr_valid, i_rx_valid, i_tx_ready, o_tx_valid, o_tx_last, o_irq;
  logic [7:0]  i_hdr_id, i_rx_data, o_tx_data;
  logic [10:0] i_mod_value1 = 11'h0, i_mod_value2 = 11'h0, i_mod_value3 = 11'h0;
  logic [2:0]  i_mod_overflow = 3'h0, o_channel_enable;
  logic [3:0]  i_intensity = 4'h0;
  logic [5:0]  i_fade_duration = 6'h0;
  logic        i_fade_enable = 1'b0, i_fade_curve = 1'b0, o_thermal_control;
  logic        o_calibration_enable, o_modulation_frequency_select, o_led_master_switch;
  logic [7:0]  d [9];
  logic [7:0]  e [9];
  int          error_cnt = 0, tests_run = 0, cyc = 0;
  wire  [6:0]  ctl = {o_calibration_enable, o_modulation_frequency_select, o_led_master_switch,
                      o_thermal_control, o_channel_enable};
  lcl_led_control lcl_led_control_i (
    .i_core_clk, .i_reset, .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready,
    .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp,
    .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready,
    .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready, .i_hdr_valid,
    .i_hdr_id, .i_rx_valid, .i_rx_data, .o_tx_valid, .o_tx_data, .o_tx_last, .i_tx_ready,
    .i_mod_value1, .i_mod_value2, .i_mod_value3, .i_mod_overflow, .i_intensity,
    .i_fade_enable, .i_fade_curve, .i_fade_duration, .o_calibration_enable,
    .o_modulation_frequency_select, .o_led_master_switch, .o_thermal_control,
    .o_channel_enable, .o_irq
  );
  lcl_lin_master lcl_lin_master_i (
    .i_core_clk, .o_hdr_valid(i_hdr_valid), .o_hdr_id(i_hdr_id), .o_rx_valid(i_rx_valid),
    .o_rx_data(i_rx_data), .i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data),
    .i_tx_last(o_tx_last), .o_tx_ready(i_tx_ready)
  );
  always #2 i_core_clk = ~i_core_clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge i_core_clk);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= v;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= 1'b1;
    do begin
      @(posedge i_core_clk);
      if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
      if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
    end while (o_s_axi_bvalid !== 1'b1);
    i_s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a);
    @(posedge i_core_clk);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= 1'b1;
    do begin
      @(posedge i_core_clk);
      if (o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
    end while (o_s_axi_rvalid !== 1'b1);
    rd = o_s_axi_rdata;
    i_s_axi_rready <= 1'b0;
  endtask
  task automatic ctrl_frame(input logic [7:0] b1, input logic [15:0] m, input logic [7:0] cb,
                            input logic bad);
    d[0] = b1;
    d[1] = m[7:0];
    d[2] = m[15:8];
    d[3] = cb;
    lcl_lin_master_i.send(CTRL_WR_ID, d, WR_LEN, bad);
    repeat (3) @(posedge i_core_clk);
  endtask
  task automatic req;
    d[0] = {ADDR_TOP, NODE};
    d[1] = FILL_BYTE;
    lcl_lin_master_i.send(REQ_ID, d, 2, 1'b0);
  endtask
  task automatic rd_ans(input logic [7:0] id, input int n);
    e[n] = lcl_lin_master_i.cks(e, n);
    lcl_lin_master_i.answer(id, n);
    for (int k = 0; k <= n; k++) begin
      chk(lcl_lin_master_i.got[k], e[k]);
      chk(lcl_lin_master_i.lst[k], k == n);
    end
  endtask
  task automatic t_regs;
    axi_rd(ADDR_CONTROL);
    chk(rd, 32'h1);
    axi_wr(ADDR_CONFIG, {20'h0, 4'h9, 2'b00, NODE});
    axi_rd(ADDR_CONFIG);
    chk(rd, 32'h915);
    $display("register test done");
  endtask
  task automatic t_write;
    ctrl_frame({ADDR_TOP, NODE}, 16'h0000, 8'hB5, 1'b0);
    chk(ctl, 7'h5A);
    ctrl_frame({ADDR_TOP, NODE ^ 6'h01}, 16'hFFFF, 8'h4B, 1'b0);
    chk(ctl, 7'h5A);
    ctrl_frame({2'b01, NODE ^ 6'h01}, 16'h0200, 8'h4B, 1'b0);
    chk(ctl, 7'h25);
    ctrl_frame({2'b01, NODE}, 16'hFDFF, 8'hB5, 1'b0);
    chk(ctl, 7'h25);
    ctrl_frame({ADDR_TOP, NODE}, 16'h0000, 8'hB5, 1'b1);
    chk(ctl, 7'h25);
    $display("control write test done");
  endtask
  task automatic t_ctrl_read;
    lcl_lin_master_i.stall = 2;
    req();
    e[0] = {ADDR_TOP, NODE};
    e[1] = 8'h4B;
    rd_ans(CTRL_RESP_ID, 2);
    $display("control read-back test done");
  endtask
  task automatic t_color;
    lcl_lin_master_i.stall = 0;
    @(posedge i_core_clk);
    i_mod_value1 <= 11'h7A5;
    i_mod_value2 <= 11'h30C;
    i_mod_value3 <= 11'h4F1;
    i_mod_overflow <= 3'b101;
    i_intensity <= 4'hC;
    i_fade_enable <= 1'b1;
    i_fade_curve <= 1'b1;
    i_fade_duration <= 6'h2D;
    req();
    e = '{8'h00, 8'hA5, 8'hFF, 8'h0C, 8'hF3, 8'hF1, 8'hCC, 8'hED, 8'h00};
    e[0] = {ADDR_TOP, NODE};
    rd_ans(COLOR_RESP_ID, 8);
    $display("color read-back test done");
  endtask
  task automatic t_irq;
    axi_rd(ADDR_STATUS);
    chk(rd, 32'h7);
    chk(o_irq, 1'b0);
    axi_wr(ADDR_MASK, 32'h2);
    repeat (2) @(posedge i_core_clk);
    chk(o_irq, 1'b1);
    axi_wr(ADDR_STATUS, 32'h7);
    repeat (2) @(posedge i_core_clk);
    chk(o_irq, 1'b0);
    axi_wr(ADDR_CONTROL, 32'h0);
    axi_rd(ADDR_CONTROL);
    chk(rd, 32'h4B);
    $display("interrupt test done");
  endtask
  task automatic t_disable;
    axi_wr(ADDR_CONFIG, 32'h10915);
    ctrl_frame({ADDR_TOP, NODE}, 16'h0000, 8'hB5, 1'b0);
    chk(ctl, 7'h25);
    $display("command disable test done");
  endtask
  initial begin
    repeat (2) @(posedge i_core_clk);
    i_reset <= 1'b0;
    t_regs();
    t_write();
    t_ctrl_read();
    t_color();
    t_irq();
    t_disable();
    report_and_stop();
  end
endmodule // lin_color_readback_led_control_test
